// file: logic/uvc_exec.sv
// Executor for immediate calculation, restart and decrement-and-branch
// How it works
// - Code 45 applies type-selected operation to indexed variable with value; writes back.
// - Variable index 0..255 selects one of 256 storage words.
// - Types 0..4: add, subtract, multiply, divide, modulo with operand.
// - Types 5..7: and, or, xor; type 8 inverts variable, operand ignored.
// - Type 9 loads operand; 11 compares only; 10 is refused.
// - Good immediate calculation from host answers status 100.
// - Restart stops program, resets interpreter, resumes at value address.
// - Restart clears return stack, interrupt stack and registers in the same cycle that loads the counter.
// - Restart acts at any nesting depth, subroutine or interrupt.
// - Code 49 takes variable index from type, target from value, ignores bank.
// - Decrement variable; nonzero result branches, zero continues with next instruction.
`timescale 1ns/10ps
module uvc_exec #(
    parameter int          ADDR_W = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              rx_valid,      // Command byte strobe from the host link
    input  wire logic [7:0]        rx_byte,
    input  wire logic              prog_valid,    // Stored program instruction request
    input  wire logic [7:0]        prog_instr,
    input  wire logic [7:0]        prog_type,
    input  wire logic [7:0]        prog_bank,
    input  wire logic [31:0]       prog_value,
    output logic                   prog_done,     // Stored instruction finished
    output logic                   pc_load,       // Program counter load pulse
    output logic [ADDR_W-1:0]      pc_value,
    output logic                   interp_reset,  // Clears stacks and registers
    output logic                   tx_valid,      // Reply byte strobe
    output logic [7:0]             tx_byte,
    output logic                   cmp_flag_eq,   // Last compare: equal
    output logic                   cmp_flag_gt    // Last compare: var greater, signed
);
    // =====================================================================
    // State and storage
    // =====================================================================
    logic [31:0]              var_mem [uvc_pkg::VAR_COUNT];
    uvc_pkg::uvc_state_t      state_q, state_d;
    logic [3:0]               cnt_q, cnt_d;
    logic [7:0]               frm_q [uvc_pkg::FRAME_BYTES];
    logic [7:0]               sum_q, sum_d;
    logic                     src_host_q, src_host_d;
    logic [7:0]               instr_q, instr_d, type_q, type_d, bank_q, bank_d;
    logic [31:0]              value_q, value_d, var_q, var_d;
    logic [7:0]               status_q, status_d;
    logic [31:0]              result;
    logic                     wr_en, res_valid, is_calc, is_rst, is_decrement_branch_nonzero;
    logic [7:0]               var_idx;
    logic [7:0]               rep [uvc_pkg::FRAME_BYTES];
    logic                     prog_done_d, pc_load_d, interp_reset_d, tx_valid_d;
    logic [ADDR_W-1:0]        pc_value_d;
    logic [7:0]               tx_byte_d;
    logic                     eq_d, gt_d;

    assign is_calc = (instr_q == uvc_pkg::OP_USER_VAR_IMMEDIATE_CALC);
    assign is_rst  = (instr_q == uvc_pkg::OP_RESTART);
    assign is_decrement_branch_nonzero = (instr_q == uvc_pkg::OP_DECREMENT_BRANCH_NONZERO);
    // eight bit index covers all 256 words
    assign var_idx = is_decrement_branch_nonzero ? type_q : bank_q;

    // =====================================================================
    // Arithmetic unit
    // =====================================================================
    // Divide by zero leaves the variable unchanged; the hardware divider is
    // big but a single cycle keeps the sequencer trivial.
    always_comb
    begin
        result    = var_q;
        res_valid = 1'b1;
        wr_en     = 1'b0;
        if (is_calc)
        begin
            wr_en = 1'b1;
            unique case (type_q)
                uvc_pkg::CALC_ADD:  result = var_q + value_q;
                uvc_pkg::CALC_SUB:  result = var_q - value_q;
                uvc_pkg::CALC_MUL:  result = 32'(signed'(var_q) * signed'(value_q));
                uvc_pkg::CALC_DIV:
                    if (value_q != 32'h0000_0000)
                        result = 32'(signed'(var_q) / signed'(value_q));
                    else
                        res_valid = 1'b0;
                uvc_pkg::CALC_MODULO_OPERATION:
                    if (value_q != 32'h0000_0000)
                        result = 32'(signed'(var_q) % signed'(value_q));
                    else
                        res_valid = 1'b0;
                uvc_pkg::CALC_AND:  result = var_q & value_q;
                uvc_pkg::CALC_OR:   result = var_q | value_q;
                uvc_pkg::CALC_XOR:  result = var_q ^ value_q;
                uvc_pkg::CALC_NOT:  result = ~var_q;
                uvc_pkg::CALC_LOAD: result = value_q;
                uvc_pkg::CALC_COMP: wr_en = 1'b0;
                default:
                begin
                    wr_en     = 1'b0;
                    res_valid = 1'b0;
                end
            endcase
            wr_en = wr_en & res_valid;
        end
        else if (is_decrement_branch_nonzero)
        begin
            result = var_q - 32'h0000_0001;
            wr_en  = 1'b1;
        end
    end

    // Reply frame bytes, checksum last
    always_comb
    begin
        rep[0] = uvc_pkg::HOST_ADDR_RESET;
        rep[1] = uvc_pkg::MODULE_ADDR_RESET;
        rep[2] = status_q;
        rep[3] = instr_q;
        rep[4] = value_q[31:24];
        rep[5] = value_q[23:16];
        rep[6] = value_q[15:8];
        rep[7] = value_q[7:0];
        rep[8] = 8'(rep[0] + rep[1] + rep[2] + rep[3] + rep[4] + rep[5] + rep[6] + rep[7]);
    end

    // =====================================================================
    // Sequencer
    // =====================================================================
    always_comb
    begin
        state_d        = state_q;
        cnt_d          = cnt_q;
        sum_d          = sum_q;
        src_host_d     = src_host_q;
        instr_d        = instr_q;
        type_d         = type_q;
        bank_d         = bank_q;
        value_d        = value_q;
        var_d          = var_q;
        status_d       = status_q;
        prog_done_d    = 1'b0;
        pc_load_d      = 1'b0;
        pc_value_d     = pc_value;
        interp_reset_d = 1'b0;
        tx_valid_d     = 1'b0;
        tx_byte_d      = tx_byte;
        eq_d           = cmp_flag_eq;
        gt_d           = cmp_flag_gt;
        unique case (state_q)
            uvc_pkg::ST_IDLE:
                // host bytes assembled in order, value most significant first
                if (rx_valid)
                begin
                    cnt_d = 4'(cnt_q + 4'h1);
                    sum_d = 8'(sum_q + rx_byte);
                    if (cnt_q == 4'(uvc_pkg::FRAME_BYTES - 1))
                    begin
                        cnt_d      = 4'h0;
                        sum_d      = 8'h00;
                        src_host_d = 1'b1;
                        instr_d    = frm_q[1];
                        type_d     = frm_q[2];
                        bank_d     = frm_q[3];
                        value_d    = {frm_q[4], frm_q[5], frm_q[6], frm_q[7]};
                        status_d   = (rx_byte == sum_q) ? uvc_pkg::STATUS_OK
                                                        : uvc_pkg::STATUS_BAD_CHECKSUM;
                        state_d    = uvc_pkg::ST_READ;
                    end
                end
                else if (prog_valid && !prog_done) // Request held in done cycle not retaken
                begin
                    src_host_d = 1'b0;
                    instr_d    = prog_instr;
                    type_d     = prog_type;
                    bank_d     = prog_bank;
                    value_d    = prog_value;
                    status_d   = uvc_pkg::STATUS_OK;
                    state_d    = uvc_pkg::ST_READ;
                end
            uvc_pkg::ST_READ:
            begin
                var_d   = var_mem[var_idx];
                state_d = uvc_pkg::ST_EXEC;
                if (status_q != uvc_pkg::STATUS_OK)
                    state_d = uvc_pkg::ST_REPLY;
                // host may not issue restart or decrement-branch
                else if (!(is_calc || ((is_rst || is_decrement_branch_nonzero) && !src_host_q)))
                begin
                    status_d = uvc_pkg::STATUS_BAD_COMMAND;
                    state_d  = uvc_pkg::ST_REPLY;
                end
            end
            uvc_pkg::ST_EXEC:
            begin
                state_d = uvc_pkg::ST_REPLY;
                if (is_calc)
                begin
                    if (!res_valid)
                        status_d = (type_q > uvc_pkg::CALC_COMP) ||
                                   (type_q == 8'h0A) ? uvc_pkg::STATUS_BAD_TYPE
                                                     : uvc_pkg::STATUS_BAD_VALUE;
                    if (type_q == uvc_pkg::CALC_COMP)
                    begin
                        eq_d = (var_q == value_q);
                        gt_d = (signed'(var_q) > signed'(value_q));
                    end
                end
                else if (is_rst)
                begin
                    interp_reset_d = 1'b1;
                    pc_load_d      = 1'b1;
                    pc_value_d     = value_q[ADDR_W-1:0];
                end
                else if (result != 32'h0000_0000)
                begin
                    pc_load_d  = 1'b1;
                    pc_value_d = value_q[ADDR_W-1:0];
                end
            end
            uvc_pkg::ST_REPLY:
                if (src_host_q)
                    state_d = uvc_pkg::ST_SEND;
                else
                begin
                    prog_done_d = 1'b1;
                    state_d     = uvc_pkg::ST_IDLE;
                end
            uvc_pkg::ST_SEND:
            begin
                tx_valid_d = 1'b1;
                tx_byte_d  = rep[cnt_q];
                cnt_d      = 4'(cnt_q + 4'h1);
                if (cnt_q == 4'(uvc_pkg::FRAME_BYTES - 1))
                begin
                    cnt_d   = 4'h0;
                    state_d = uvc_pkg::ST_IDLE;
                end
            end
            default: state_d = uvc_pkg::ST_IDLE;
        endcase
    end

    // Registers of the sequencer
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state_q      <= uvc_pkg::ST_IDLE;
            cnt_q        <= 4'h0;
            sum_q        <= 8'h00;
            src_host_q   <= 1'b0;
            instr_q      <= 8'h00;
            type_q       <= 8'h00;
            bank_q       <= 8'h00;
            value_q      <= 32'h0000_0000;
            var_q        <= 32'h0000_0000;
            status_q     <= uvc_pkg::STATUS_OK;
            prog_done    <= 1'b0;
            pc_load      <= 1'b0;
            pc_value     <= '0;
            interp_reset <= 1'b0;
            tx_valid     <= 1'b0;
            tx_byte      <= 8'h00;
            cmp_flag_eq  <= 1'b0;
            cmp_flag_gt  <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            cnt_q        <= cnt_d;
            sum_q        <= sum_d;
            src_host_q   <= src_host_d;
            instr_q      <= instr_d;
            type_q       <= type_d;
            bank_q       <= bank_d;
            value_q      <= value_d;
            var_q        <= var_d;
            status_q     <= status_d;
            prog_done    <= prog_done_d;
            pc_load      <= pc_load_d;
            pc_value     <= pc_value_d;
            interp_reset <= interp_reset_d;
            tx_valid     <= tx_valid_d;
            tx_byte      <= tx_byte_d;
            cmp_flag_eq  <= eq_d;
            cmp_flag_gt  <= gt_d;
        end
    end

    // Frame byte capture and variable write back; storage has no reset
    always_ff @(posedge sys_clk)
    begin
        if (state_q == uvc_pkg::ST_IDLE && rx_valid)
            frm_q[cnt_q] <= rx_byte;
        // result written back to the variable
        if (state_q == uvc_pkg::ST_EXEC && wr_en)
            var_mem[var_idx] <= result;
    end

endmodule // uvc_exec

// file: logic/uvc_pkg.sv
// Package with constants for the user variable calculate and branch executor
package uvc_pkg;
    // =====================================================================
    // Instruction codes and frame layout
    // =====================================================================
    localparam logic [7:0]  OP_USER_VAR_IMMEDIATE_CALC   = 8'h2D;   // 45
    localparam logic [7:0]  OP_RESTART                   = 8'h30;   // 48
    localparam logic [7:0]  OP_DECREMENT_BRANCH_NONZERO  = 8'h31;   // 49
    localparam int          FRAME_BYTES                  = 9;
    localparam logic [7:0]  HOST_ADDR_RESET              = 8'h02;
    localparam logic [7:0]  MODULE_ADDR_RESET            = 8'h01;
    // =====================================================================
    // Calculation type codes
    // =====================================================================
    localparam logic [7:0]  CALC_ADD                     = 8'h00;
    localparam logic [7:0]  CALC_SUB                     = 8'h01;
    localparam logic [7:0]  CALC_MUL                     = 8'h02;
    localparam logic [7:0]  CALC_DIV                     = 8'h03;
    localparam logic [7:0]  CALC_MODULO_OPERATION        = 8'h04;
    localparam logic [7:0]  CALC_AND                     = 8'h05;
    localparam logic [7:0]  CALC_OR                      = 8'h06;
    localparam logic [7:0]  CALC_XOR                     = 8'h07;
    localparam logic [7:0]  CALC_NOT                     = 8'h08;
    localparam logic [7:0]  CALC_LOAD                    = 8'h09;
    localparam logic [7:0]  CALC_COMP                    = 8'h0B;
    // =====================================================================
    // Status codes
    // =====================================================================
    localparam logic [7:0]  STATUS_OK                    = 8'h64;   // 100
    localparam logic [7:0]  STATUS_BAD_CHECKSUM          = 8'h01;
    localparam logic [7:0]  STATUS_BAD_COMMAND           = 8'h02;
    localparam logic [7:0]  STATUS_BAD_TYPE              = 8'h03;
    localparam logic [7:0]  STATUS_BAD_VALUE             = 8'h04;
    localparam int          VAR_COUNT                    = 256;
    // Executor states, Gray coded along the usual path except the SEND to IDLE return
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_EXEC  = 3'b011,
        ST_REPLY = 3'b010,
        ST_SEND  = 3'b110
    } uvc_state_t;
endpackage

// file: testbench/uvc_exec_asserts.sv
// Port-level checks on the executor
`timescale 1ns/10ps
module uvc_exec_asserts #(
    parameter int ADDR_W = 16
) (
    input wire logic              sys_clk,
    input wire logic              rst_b,
    input wire logic              rx_valid,
    input wire logic [7:0]        rx_byte,
    input wire logic              prog_valid,
    input wire logic [7:0]        prog_instr,
    input wire logic [7:0]        prog_type,
    input wire logic [7:0]        prog_bank,
    input wire logic [31:0]       prog_value,
    input wire logic              prog_done,
    input wire logic              pc_load,
    input wire logic [ADDR_W-1:0] pc_value,
    input wire logic              interp_reset,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_byte,
    input wire logic              cmp_flag_eq,
    input wire logic              cmp_flag_gt
);
    // =====================================================================
    // Reply byte count and running sum
    // =====================================================================
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] sum_q;
    logic [7:0] sum_d;
    // Sum restarts at every gap, so one reply never leaks into the next
    always_comb
    begin
        cnt_d = tx_valid ? cnt_q + 4'h1 : 4'h0;
        sum_d = tx_valid ? sum_q + tx_byte : 8'h00;
    end
    always_ff @(posedge sys_clk)
    begin
        cnt_q <= rst_b ? cnt_d : 4'h0;
        sum_q <= rst_b ? sum_d : 8'h00;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b |=> !tx_valid && !pc_load && !prog_done && !interp_reset)
        else $error("outputs active after reset");
    // Helper count reaches nine on the cycle after the last reply byte
    a_reply_length: assert property ($fell(tx_valid) |-> cnt_q == 4'h9)
        else $error("reply is not nine bytes");
    a_reply_head: assert property ($rose(tx_valid) |->
        tx_byte == uvc_pkg::HOST_ADDR_RESET ##1 tx_byte == uvc_pkg::MODULE_ADDR_RESET)
        else $error("reply addresses wrong");
    a_reply_sum: assert property (tx_valid && cnt_q == 4'h8 |-> tx_byte == sum_q)
        else $error("reply checksum wrong");
    a_load_target: assert property (pc_load |->
        $past(prog_valid, 3) && pc_value == $past(prog_value[ADDR_W-1:0], 3))
        else $error("counter load without cause or wrong target");
    a_restart_clear: assert property (interp_reset |->
        pc_load && $past(prog_instr, 3) == uvc_pkg::OP_RESTART)
        else $error("interpreter clear not tied to restart");
    a_done_after: assert property (pc_load |=> prog_done ##1 !prog_done)
        else $error("done does not follow load");
    a_pc_holds: assert property (!pc_load |-> $stable(pc_value))
        else $error("counter changed without load");
endmodule // uvc_exec_asserts

// file: testbench/uvc_host_model.sv
// Host model that sends command frames and gathers replies
`timescale 1ns/10ps
module uvc_host_model (
    input wire logic       sys_clk,
    output logic           rx_valid,
    output logic [7:0]     rx_byte,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_byte
);
    // =====================================================================
    // Reply capture and frame sender
    // =====================================================================
    logic [7:0] rep_q[$];
    initial
    begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Reply bytes are only one cycle wide, so catch every one
    always @(posedge sys_clk)
        if (tx_valid === 1'b1)
            rep_q.push_back(tx_byte);
    task automatic send(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                        input logic [7:0] flip, output logic [7:0] rep[9], output bit ok);
        logic [7:0] fr[9];
        int n;
        fr = '{8'h01, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (n = 0; n < 8; n++)
            fr[8] += fr[n];
        // Nonzero flip spoils the checksum on purpose
        fr[8] ^= flip;
        rep_q.delete();
        for (n = 0; n < 9; n++)
        begin
            @(posedge sys_clk);
            rx_valid <= 1'b1;
            rx_byte <= fr[n];
        end
        // Released line shows the inverse, never a stale byte
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~fr[8];
        ok = 0;
        for (n = 0; n < 40 && !ok; n++)
        begin
            @(negedge sys_clk);
            ok = (rep_q.size() == 9);
        end
        for (n = 0; n < 9; n++)
            rep[n] = ok ? rep_q[n] : 8'h00;
    endtask
endmodule // uvc_host_model

// file: testbench/tb.sv
// Self-checking bench for the executor
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] CV = uvc_pkg::OP_USER_VAR_IMMEDIATE_CALC;
    logic sys_clk, rst_b, rx_valid, prog_valid, prog_done, pc_load, interp_reset;
    logic tx_valid, cmp_flag_eq, cmp_flag_gt;
    logic [7:0]  rx_byte, prog_instr, prog_type, prog_bank, tx_byte;
    logic [31:0] prog_value;
    logic [15:0] pc_value;
    int          failures;
    int          check_count;
    logic [7:0]  sum_flip;
    // =====================================================================
    // Clock, design and host
    // =====================================================================
    initial
        sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    uvc_exec #(.ADDR_W(16)) uvc_exec_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .prog_valid(prog_valid),
        .prog_instr(prog_instr), .prog_type(prog_type), .prog_bank(prog_bank),
        .prog_value(prog_value), .prog_done(prog_done), .pc_load(pc_load),
        .pc_value(pc_value), .interp_reset(interp_reset), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .cmp_flag_eq(cmp_flag_eq), .cmp_flag_gt(cmp_flag_gt));
    uvc_host_model uvc_host_model_inst (.sys_clk(sys_clk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reference result; signed, as the designer chose
    function automatic logic [31:0] calc_ref(input logic [7:0] t, input logic [31:0] a, b);
        case (t)
            8'h00: return a + b;
            8'h01: return a - b;
            8'h02: return a * b;
            8'h03: return $signed(a) / $signed(b);
            8'h04: return $signed(a) % $signed(b);
            8'h05: return a & b;
            8'h06: return a | b;
            8'h07: return a ^ b;
            8'h08: return ~a;
            8'h09: return b;
            default: return a;
        endcase
    endfunction
    task automatic host_op(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                           input logic [7:0] st);
        logic [7:0] rep[9];
        logic [7:0] sum;
        bit ok;
        uvc_host_model_inst.send(ins, typ, bank, val, sum_flip, rep, ok);
        chk("reply_seen", 1, ok);
        if (!ok)
            wrap_up();
        sum = rep[0] + rep[1] + rep[2] + rep[3] + rep[4] + rep[5] + rep[6] + rep[7];
        chk("host_addr", 8'h02, rep[0]);
        chk("target_addr", uvc_pkg::MODULE_ADDR_RESET, rep[1]);
        chk("status", st, rep[2]);
        chk("instr", ins, rep[3]);
        chk("value", val, {rep[4], rep[5], rep[6], rep[7]});
        chk("checksum", sum, rep[8]);
    endtask
    task automatic prog_op(input logic [7:0] ins, typ, input logic [31:0] val,
                           input bit ld, rs, input logic [15:0] pc);
        bit seen_ld, seen_rs, done;
        int n;
        seen_ld = 0;
        seen_rs = 0;
        done = 0;
        @(posedge sys_clk);
        prog_valid <= 1'b1;
        prog_instr <= ins;
        prog_type <= typ;
        prog_bank <= 8'h55;
        prog_value <= val;
        for (n = 0; n < 12 && !done; n++)
        begin
            @(negedge sys_clk);
            seen_ld |= (pc_load === 1'b1);
            seen_rs |= (interp_reset === 1'b1);
            done = (prog_done === 1'b1);
        end
        // Released on the edge that samples done; the executor ignores it there
        @(posedge sys_clk);
        prog_valid <= 1'b0;
        chk("prog_done", 1, done);
        if (!done)
            wrap_up();
        chk("pc_load", ld, seen_ld);
        chk("interp_reset", rs, seen_rs);
        chk("pc_value", pc, pc_value);
    endtask
    // Every type code except 10 on the top index, read back through compare
    task automatic t_calc();
        logic [7:0] t;
        for (t = 8'h00; t < 8'h0C; t++)
        begin
            if (t == 8'h0A)
                continue;
            host_op(CV, 8'h09, 8'hFF, 32'h0000_03E8, uvc_pkg::STATUS_OK);
            host_op(CV, t, 8'hFF, 32'h0000_0007, uvc_pkg::STATUS_OK);
            host_op(CV, 8'h0B, 8'hFF, calc_ref(t, 32'h0000_03E8, 32'h0000_0007),
                    uvc_pkg::STATUS_OK);
            chk("cmp_flag_eq", 1, cmp_flag_eq);
            chk("cmp_flag_gt", 0, cmp_flag_gt);
        end
        $display("test calc done");
    endtask
    // Missing type, host-only refusals, divide by zero leaves the variable
    task automatic t_refuse();
        host_op(CV, 8'h0A, 8'h05, 32'h0000_0001, uvc_pkg::STATUS_BAD_TYPE);
        host_op(uvc_pkg::OP_RESTART, 8'h00, 8'h00, 32'h0000_000A,
                uvc_pkg::STATUS_BAD_COMMAND);
        host_op(uvc_pkg::OP_DECREMENT_BRANCH_NONZERO, 8'h00, 8'h00, 32'h0000_0001,
                uvc_pkg::STATUS_BAD_COMMAND);
        host_op(CV, 8'h09, 8'h05, 32'h0000_0021, uvc_pkg::STATUS_OK);
        host_op(CV, 8'h03, 8'h05, 32'h0000_0000, uvc_pkg::STATUS_BAD_VALUE);
        sum_flip = 8'hFF;
        host_op(CV, 8'h09, 8'h05, 32'h0000_0099, uvc_pkg::STATUS_BAD_CHECKSUM);
        sum_flip = 8'h00;
        host_op(CV, 8'h0B, 8'h05, 32'h0000_0021, uvc_pkg::STATUS_OK);
        chk("cmp_flag_eq", 1, cmp_flag_eq);
        host_op(CV, 8'h0B, 8'h05, 32'hFFFF_FFFF, uvc_pkg::STATUS_OK);
        chk("cmp_flag_eq", 0, cmp_flag_eq);
        chk("cmp_flag_gt", 1, cmp_flag_gt);
        $display("test refuse done");
    endtask
    // Restart clears and loads; loop counter on index zero branches once
    task automatic t_prog();
        prog_op(uvc_pkg::OP_RESTART, 8'h00, 32'h0000_000A, 1, 1, 16'h000A);
        host_op(CV, 8'h09, 8'h00, 32'h0000_0002, uvc_pkg::STATUS_OK);
        prog_op(uvc_pkg::OP_DECREMENT_BRANCH_NONZERO, 8'h00, 32'h0000_0001, 1, 0,
                16'h0001);
        prog_op(uvc_pkg::OP_DECREMENT_BRANCH_NONZERO, 8'h00, 32'h0000_0030, 0, 0,
                16'h0001);
        host_op(CV, 8'h0B, 8'h00, 32'h0000_0000, uvc_pkg::STATUS_OK);
        chk("cmp_flag_eq", 1, cmp_flag_eq);
        $display("test program done");
    endtask
    initial
    begin
        failures = 0;
        check_count = 0;
        sum_flip = 8'h00;
        rst_b = 1'b0;
        prog_valid = 1'b0;
        prog_instr = 8'h00;
        prog_type = 8'h00;
        prog_bank = 8'h00;
        prog_value = 32'h0000_0000;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_calc();
        t_refuse();
        t_prog();
        wrap_up();
    end
endmodule // tb
bind uvc_exec uvc_exec_asserts #(.ADDR_W(ADDR_W)) uvc_exec_asserts_inst (.sys_clk(sys_clk),
    .rst_b(rst_b), .rx_valid(rx_valid), .rx_byte(rx_byte), .prog_valid(prog_valid),
    .prog_instr(prog_instr), .prog_type(prog_type), .prog_bank(prog_bank),
    .prog_value(prog_value), .prog_done(prog_done), .pc_load(pc_load),
    .pc_value(pc_value), .interp_reset(interp_reset), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .cmp_flag_eq(cmp_flag_eq), .cmp_flag_gt(cmp_flag_gt));
